// file: hdl/csf_pkg.sv
// Constants shared by the clock select and oscillator fault logic.
// Assumes a 32-bit APB register bus with word-aligned registers.
package csf_pkg;

  // Register byte offsets
  localparam logic [7:0] OSC_CTRL_OFS   = 8'h00;  // Oscillator control register
  localparam logic [7:0] CLK_SEL_OFS    = 8'h04;  // Clock select register
  localparam logic [7:0] FAULT_FLAG_OFS = 8'h08;  // Fault flag register (write one to clear)
  localparam logic [7:0] SYS_CTRL_OFS   = 8'h0C;  // Fault interrupt enable, sleep, status

  // Oscillator control register fields
  localparam int OSC_BYPASS_BIT  = 0;  // Oscillator bypass bit (first oscillator)
  localparam int OSC_HF_MODE_BIT = 1;  // First oscillator in high-frequency mode
  localparam int OSC2_BYPASS_BIT = 2;  // Second oscillator digital bypass
  localparam int OSC1_OFF_BIT    = 3;  // First oscillator switched off
  localparam int OSC2_OFF_BIT    = 4;  // Second oscillator switched off
  localparam int OSC_CTRL_W      = 5;
  localparam logic [OSC_CTRL_W-1:0] OSC_CTRL_RST = 5'h18;  // Both oscillators off

  // Clock select register fields: three 3-bit source codes
  localparam int SEL_W          = 3;
  localparam int MAIN_SEL_LSB   = 0;
  localparam int SUBMAIN_SEL_LSB = 4;
  localparam int AUX_SEL_LSB    = 8;
  localparam logic [SEL_W-1:0] MAIN_SEL_RST    = 3'h3;
  localparam logic [SEL_W-1:0] SUBMAIN_SEL_RST = 3'h3;
  localparam logic [SEL_W-1:0] AUX_SEL_RST     = 3'h2;

  // Fault flag register fields
  localparam int FAULT1_BIT     = 0;  // First oscillator fault
  localparam int FAULT2_BIT     = 1;  // Second oscillator fault
  localparam int COMBINED_BIT   = 2;  // Combined oscillator fault (read only)
  localparam int FAULT_W        = 2;

  // System control register fields
  localparam int NMI_EN_BIT     = 0;  // Fault non-maskable interrupt enable
  localparam int SLEEP_REQ_BIT  = 1;  // Deepest sleep mode requested
  localparam int LOW_CUR_BIT    = 8;  // Power manager in low-current mode (read only)
  localparam int BYPASS_ON_BIT  = 9;  // Second bypass, or first bypass in HF mode, still running (read only)

endpackage : csf_pkg

// file: hdl/csf_flag_if.sv
// Carrier between the register block and the fault flag keeper.
// Assumes both sides run on the same system clock.
interface csf_flag_if;
  logic       sel_change;   // One-cycle pulse: a select field changed value
  logic [1:0] clear_mask;   // One-cycle pulse: flags to clear
  logic [1:0] osc_absent;   // Crystal missing or oscillator unconfigured
  logic [1:0] raw_fault;    // Synchronised fault from the oscillators
  logic [1:0] flags;        // Sticky oscillator fault flags
  logic       combined;     // OR of the flags

  modport ctrl (output sel_change, output clear_mask, output osc_absent,
                output raw_fault, input flags, input combined);
  modport keep (input sel_change, input clear_mask, input osc_absent,
                input raw_fault, output flags, output combined);
endinterface : csf_flag_if

// file: hdl/csf_fault_keeper.sv
// Sticky oscillator fault flags and the combined fault flag.
// Assumes all inputs are already synchronous to clk_sys.
module csf_fault_keeper (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Flag traffic
  csf_flag_if.keep  fl
);

  logic [1:0] flags_reg;   // Sticky fault flags
  logic [1:0] flags_next;
  logic       comb_reg;    // Combined flag
  logic       comb_next;
  logic [1:0] spurious;    // Spurious set on a select change

  // Next flag values
  always_comb begin
    spurious   = fl.sel_change ? fl.osc_absent : 2'h0;
    flags_next = (flags_reg & ~fl.clear_mask) | fl.raw_fault | spurious;
    comb_next  = |flags_next;
  end

  // Flag registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_reg <= 2'h0;
      comb_reg  <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      comb_reg  <= comb_next;
    end
  end

  assign fl.flags    = flags_reg;
  assign fl.combined = comb_reg;

endmodule : csf_fault_keeper

// file: hdl/csf_clock_select.sv
// Clock source selection, oscillator fault flagging and sleep gating.
// Assumes an APB master on clk_sys and oscillator status pins from
// outside the clock domain.

// Operation
// - second bypass, or first bypass in HF mode, left running blocks low-current sleep
// - select write routes clocks to new source
// - select change may set absent oscillator fault
// - spurious fault regardless of changed field
// - enabled fault interrupt fires on spurious flag
module csf_clock_select (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Oscillator pins (asynchronous)
  input  wire logic                   osc1_present,
  input  wire logic                   osc2_present,
  input  wire logic                   osc1_fault_in,
  input  wire logic                   osc2_fault_in,
  // Clock routing and system outputs
  output logic [csf_pkg::SEL_W-1:0]   main_clock_select,
  output logic [csf_pkg::SEL_W-1:0]   submain_clock_select,
  output logic [csf_pkg::SEL_W-1:0]   aux_clock_select,
  output logic                        combined_oscillator_fault_flag,
  output logic                        fault_nmi,
  output logic                        power_manager_low_current
);

  // Pin synchronisers: stage one feeds stage two only
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;

  // Software state
  logic [csf_pkg::OSC_CTRL_W-1:0] osc_ctrl_reg;  // Oscillator control
  logic [csf_pkg::OSC_CTRL_W-1:0] osc_ctrl_next;
  logic [csf_pkg::SEL_W-1:0]      main_reg;      // Main clock source
  logic [csf_pkg::SEL_W-1:0]      main_next;
  logic [csf_pkg::SEL_W-1:0]      sub_reg;       // Sub-main clock source
  logic [csf_pkg::SEL_W-1:0]      sub_next;
  logic [csf_pkg::SEL_W-1:0]      aux_reg;       // Auxiliary clock source
  logic [csf_pkg::SEL_W-1:0]      aux_next;
  logic                           nmi_en_reg;    // Fault interrupt enable
  logic                           nmi_en_next;
  logic                           sleep_reg;     // Deepest sleep requested
  logic                           sleep_next;

  // Bus answer state
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // System outputs
  logic        nmi_reg;
  logic        nmi_next;
  logic        low_cur_reg;
  logic        low_cur_next;

  // Decoded strobes
  logic        wr_en;
  logic        setup;
  logic        bypass_on;
  logic [1:0]  clear_mask;
  logic        sel_change;

  csf_flag_if fl ();

  // True when the address names a mapped register
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == csf_pkg::OSC_CTRL_OFS) || (a == csf_pkg::CLK_SEL_OFS) ||
           (a == csf_pkg::FAULT_FLAG_OFS) || (a == csf_pkg::SYS_CTRL_OFS);
  endfunction : addr_mapped

  // Pin synchronisers, plain shift with no logic between stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {osc2_fault_in, osc1_fault_in, osc2_present, osc1_present};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Register writes and clock routing
  always_comb begin
    setup         = psel && !penable;
    // Writes land in the access cycle, which always completes at once
    wr_en         = psel && penable && pwrite;
    osc_ctrl_next = osc_ctrl_reg;
    main_next     = main_reg;
    sub_next      = sub_reg;
    aux_next      = aux_reg;
    nmi_en_next   = nmi_en_reg;
    sleep_next    = sleep_reg;
    clear_mask    = 2'h0;
    if (wr_en && paddr == csf_pkg::OSC_CTRL_OFS) begin
      osc_ctrl_next = pwdata[csf_pkg::OSC_CTRL_W-1:0];
    end else if (wr_en && paddr == csf_pkg::CLK_SEL_OFS) begin
      main_next = pwdata[csf_pkg::MAIN_SEL_LSB +: csf_pkg::SEL_W];
      sub_next  = pwdata[csf_pkg::SUBMAIN_SEL_LSB +: csf_pkg::SEL_W];
      aux_next  = pwdata[csf_pkg::AUX_SEL_LSB +: csf_pkg::SEL_W];
    end else if (wr_en && paddr == csf_pkg::FAULT_FLAG_OFS) begin
      // Write one to clear; the combined bit is not writable
      clear_mask = pwdata[csf_pkg::FAULT_W-1:0];
    end else if (wr_en && paddr == csf_pkg::SYS_CTRL_OFS) begin
      nmi_en_next = pwdata[csf_pkg::NMI_EN_BIT];
      sleep_next  = pwdata[csf_pkg::SLEEP_REQ_BIT];
    end
    // Only a real change of value counts, rewriting the same value does not
    sel_change = (main_next != main_reg) || (sub_next != sub_reg) ||
                 (aux_next != aux_reg);
  end

  // Software state registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_ctrl_reg <= csf_pkg::OSC_CTRL_RST;
      main_reg     <= csf_pkg::MAIN_SEL_RST;
      sub_reg      <= csf_pkg::SUBMAIN_SEL_RST;
      aux_reg      <= csf_pkg::AUX_SEL_RST;
      nmi_en_reg   <= 1'b0;
      sleep_reg    <= 1'b0;
    end else begin
      osc_ctrl_reg <= osc_ctrl_next;
      main_reg     <= main_next;
      sub_reg      <= sub_next;
      aux_reg      <= aux_next;
      nmi_en_reg   <= nmi_en_next;
      sleep_reg    <= sleep_next;
    end
  end

  // Flag keeper hookup
  assign fl.sel_change = sel_change;
  assign fl.clear_mask = clear_mask;
  // An oscillator counts as absent when no crystal is there or it is off
  assign fl.osc_absent = {~pin_sync_reg[1] | osc_ctrl_reg[csf_pkg::OSC2_OFF_BIT],
                          ~pin_sync_reg[0] | osc_ctrl_reg[csf_pkg::OSC1_OFF_BIT]};
  assign fl.raw_fault  = pin_sync_reg[3:2];

  csf_fault_keeper u_keeper (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fl      (fl.keep)
  );

  // Sleep gating and fault interrupt
  always_comb begin
    // a running second bypass, or first bypass in HF mode, keeps the power manager awake
    bypass_on = (osc_ctrl_reg[csf_pkg::OSC_BYPASS_BIT] &&
                 osc_ctrl_reg[csf_pkg::OSC_HF_MODE_BIT] &&
                 !osc_ctrl_reg[csf_pkg::OSC1_OFF_BIT]) ||
                (osc_ctrl_reg[csf_pkg::OSC2_BYPASS_BIT] &&
                 !osc_ctrl_reg[csf_pkg::OSC2_OFF_BIT]);
    // software must drop the bypass first
    low_cur_next = sleep_reg && !bypass_on;
    // masking the enable holds it off
    nmi_next     = nmi_en_reg && fl.combined;
  end

  // Bus read data, prepared in the setup cycle
  always_comb begin
    prdata_next  = 32'h0000_0000;
    pready_next  = setup;
    pslverr_next = setup && !addr_mapped(paddr);
    if (setup && !pwrite && paddr == csf_pkg::OSC_CTRL_OFS) begin
      prdata_next[csf_pkg::OSC_CTRL_W-1:0] = osc_ctrl_reg;
    end else if (setup && !pwrite && paddr == csf_pkg::CLK_SEL_OFS) begin
      prdata_next[csf_pkg::MAIN_SEL_LSB +: csf_pkg::SEL_W]    = main_reg;
      prdata_next[csf_pkg::SUBMAIN_SEL_LSB +: csf_pkg::SEL_W] = sub_reg;
      prdata_next[csf_pkg::AUX_SEL_LSB +: csf_pkg::SEL_W]     = aux_reg;
    end else if (setup && !pwrite && paddr == csf_pkg::FAULT_FLAG_OFS) begin
      prdata_next[csf_pkg::FAULT_W-1:0]   = fl.flags;
      prdata_next[csf_pkg::COMBINED_BIT]  = fl.combined;
    end else if (setup && !pwrite && paddr == csf_pkg::SYS_CTRL_OFS) begin
      prdata_next[csf_pkg::NMI_EN_BIT]    = nmi_en_reg;
      prdata_next[csf_pkg::SLEEP_REQ_BIT] = sleep_reg;
      prdata_next[csf_pkg::LOW_CUR_BIT]   = low_cur_reg;
      prdata_next[csf_pkg::BYPASS_ON_BIT] = bypass_on;
    end
  end

  // Bus answer and system output registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      nmi_reg     <= 1'b0;
      low_cur_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      nmi_reg     <= nmi_next;
      low_cur_reg <= low_cur_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata                         = prdata_reg;
  assign pready                         = pready_reg;
  assign pslverr                        = pslverr_reg;
  assign main_clock_select              = main_reg;
  assign submain_clock_select           = sub_reg;
  assign aux_clock_select               = aux_reg;
  assign combined_oscillator_fault_flag = fl.combined;
  assign fault_nmi                      = nmi_reg;
  assign power_manager_low_current      = low_cur_reg;

endmodule : csf_clock_select

// file: tb/csf_assertions.sv
// Port-level checks on the clock select and fault flag block.
// Assumes one clk_sys domain and zero-wait APB answers.
module csf_checker (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // APB side
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic                      pready,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  // Pins and outputs
  input wire logic                      osc2_present,
  input wire logic [csf_pkg::SEL_W-1:0] main_clock_select,
  input wire logic [csf_pkg::SEL_W-1:0] submain_clock_select,
  input wire logic [csf_pkg::SEL_W-1:0] aux_clock_select,
  input wire logic                      combined_oscillator_fault_flag,
  input wire logic                      fault_nmi,
  input wire logic                      power_manager_low_current
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Completed writes, split by target
  logic        acc_wr;
  logic        sel_wr;
  logic        clr_wr;
  logic        ctl_wr;
  logic [10:0] sel_now;
  assign acc_wr  = psel && penable && pready && pwrite;
  assign sel_wr  = acc_wr && (paddr == csf_pkg::CLK_SEL_OFS);
  assign clr_wr  = acc_wr && (paddr == csf_pkg::FAULT_FLAG_OFS);
  assign ctl_wr  = acc_wr && (paddr != csf_pkg::CLK_SEL_OFS);
  assign sel_now = {aux_clock_select, 1'b0, submain_clock_select, 1'b0, main_clock_select};
  // Second crystal missing long enough to pass the synchroniser
  sequence s_osc2_gone;
    !osc2_present [*3];
  endsequence
  // Only the auxiliary field moves
  sequence s_aux_only;
    sel_wr && pwdata[6:0] == sel_now[6:0] && pwdata[10:8] != aux_clock_select;
  endsequence
  property p_route;
    sel_wr |=> sel_now == ($past(pwdata[10:0]) & 11'h777);
  endproperty
  a_route: assert property (p_route) else $error("select not routed");
  property p_hold;
    !sel_wr |=> $stable(sel_now);
  endproperty
  a_hold: assert property (p_hold) else $error("select moved alone");
  property p_spur;
    s_osc2_gone ##0 (sel_wr && (pwdata[10:0] & 11'h777) != sel_now) |=> combined_oscillator_fault_flag;
  endproperty
  a_spur: assert property (p_spur) else $error("no fault on change");
  property p_any_field;
    s_osc2_gone ##0 s_aux_only |=> combined_oscillator_fault_flag;
  endproperty
  a_any_field: assert property (p_any_field) else $error("aux change no fault");
  property p_nmi;
    fault_nmi |-> $past(combined_oscillator_fault_flag);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without flag");
  property p_sticky;
    combined_oscillator_fault_flag && !clr_wr && !$past(clr_wr) |=> combined_oscillator_fault_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped alone");
  property p_sleep;
    !ctl_wr [*2] |=> $stable(power_manager_low_current);
  endproperty
  a_sleep: assert property (p_sleep) else $error("low current moved alone");
endmodule : csf_checker

bind csf_clock_select csf_checker csf_checker_inst (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
  .pwdata(pwdata), .osc2_present(osc2_present), .main_clock_select(main_clock_select),
  .submain_clock_select(submain_clock_select), .aux_clock_select(aux_clock_select),
  .combined_oscillator_fault_flag(combined_oscillator_fault_flag), .fault_nmi(fault_nmi),
  .power_manager_low_current(power_manager_low_current));

// file: tb/csf_osc_model.sv
// Crystal and clock-input pins as the clock block sees them.
// Assumes the bench sets fitting and failure on clock edges.
module csf_osc_model (
  // Bench commands
  input  wire logic fit1,
  input  wire logic fit2,
  input  wire logic fail1,
  input  wire logic fail2,
  // Oscillator pins
  output logic      osc1_present,
  output logic      osc2_present,
  output logic      osc1_fault_in,
  output logic      osc2_fault_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A fitted part shows presence; faults come only on command
  assign osc1_present  = fit1;
  assign osc2_present  = fit2;
  assign osc1_fault_in = fail1;
  assign osc2_fault_in = fail2;
endmodule : csf_osc_model

// file: tb/csf_clock_select_tb.sv
// Self-checking bench for the clock select and fault flag block.
// Assumes a 10 MHz clk_sys and zero-wait APB.
module csf_clock_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, lfsr, sel_m, ctl_m, sys_m;
  logic        fit1, fit2, fail1, fail2, p1, p2, f1, f2, comb, nmi, lowc;
  logic [2:0]  msel, ssel, asel;
  logic [1:0]  flg_m;  // Model of the sticky flags
  int          error_cnt, n_compared, cycles;
  int          ctl_q[$] = '{'h03, 'h01, 'h04, 'h14, 'h0B};

  csf_osc_model csf_osc_model_inst (.fit1(fit1), .fit2(fit2), .fail1(fail1), .fail2(fail2),
    .osc1_present(p1), .osc2_present(p2), .osc1_fault_in(f1), .osc2_fault_in(f2));
  csf_clock_select csf_clock_select_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc1_present(p1), .osc2_present(p2),
    .osc1_fault_in(f1), .osc2_fault_in(f2), .main_clock_select(msel),
    .submain_clock_select(ssel), .aux_clock_select(asel),
    .combined_oscillator_fault_flag(comb), .fault_nmi(nmi), .power_manager_low_current(lowc));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the hang guard ends a wait that never sees pready
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Next word of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // Write and keep the model in step; set wins over clear
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      csf_pkg::OSC_CTRL_OFS: ctl_m = d & 32'h0000001F;
      csf_pkg::CLK_SEL_OFS: begin
        if ((d & 32'h00000777) != sel_m) flg_m |= {!fit2 || ctl_m[4], !fit1 || ctl_m[3]};
        sel_m = d & 32'h00000777;
      end
      csf_pkg::FAULT_FLAG_OFS: flg_m &= ~d[1:0];
      default: sys_m = d & 32'h00000003;
    endcase
  endtask : wr

  task automatic rdc(input logic [7:0] a);
    logic bp;
    logic [31:0] e;
    bp = (ctl_m[0] & ctl_m[1] & !ctl_m[3]) | (ctl_m[2] & !ctl_m[4]);
    case (a)
      csf_pkg::OSC_CTRL_OFS: e = ctl_m;
      csf_pkg::CLK_SEL_OFS: e = sel_m;
      csf_pkg::FAULT_FLAG_OFS: e = {29'h0, |flg_m, flg_m};
      csf_pkg::SYS_CTRL_OFS: e = {22'h0, bp, sys_m[1] & !bp, 6'h0, sys_m[1:0]};
      default: e = 32'h0;
    endcase
    apb(1'b0, a, 32'h0);
    chk("read data", e, rd);
    chk("slave error", 32'(a > 8'h0C), 32'(err));
    if (a == csf_pkg::SYS_CTRL_OFS) chk("low current", 32'(sys_m[1] & !bp), 32'(lowc));
  endtask : rdc

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {fit1, fit2, fail1, fail2} = 4'b0100;
    {lfsr, sel_m, ctl_m, sys_m, flg_m} = {32'hE0A20BE9, 32'h233, 32'h18, 32'h0, 2'b00};
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int a = 0; a <= 16; a += 4) rdc(8'(a));
    $display("reset values and unmapped slot done");
    wr(csf_pkg::SYS_CTRL_OFS, 32'h1);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      // Second crystal missing on even passes; synced before the select write lands
      fit2 <= i[0];
      if (i == 2) wr(csf_pkg::OSC_CTRL_OFS, 32'h08);
      if (i == 5) wr(csf_pkg::SYS_CTRL_OFS, 32'h0);
      // Pass 6 moves the auxiliary field alone, pass 7 rewrites the same value
      wr(csf_pkg::CLK_SEL_OFS, (i == 7) ? sel_m : (i == 6) ? (sel_m ^ 32'h100) : lfsr);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("selects", sel_m, {21'h0, asel, 1'b0, ssel, 1'b0, msel});
      chk("nmi", 32'(sys_m[0] & |flg_m), 32'(nmi));
      rdc(csf_pkg::FAULT_FLAG_OFS);
      wr(csf_pkg::FAULT_FLAG_OFS, 32'h3);
      rdc(csf_pkg::FAULT_FLAG_OFS);
    end
    $display("select change faults done");
    fail1 <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fail1 <= 1'b0;
    flg_m[0] = 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(csf_pkg::FAULT_FLAG_OFS);
    chk("combined", 32'h1, 32'(comb));
    wr(csf_pkg::FAULT_FLAG_OFS, 32'h1);
    rdc(csf_pkg::FAULT_FLAG_OFS);
    $display("sticky fault done");
    wr(csf_pkg::SYS_CTRL_OFS, 32'h2);
    foreach (ctl_q[i]) begin
      wr(csf_pkg::OSC_CTRL_OFS, ctl_q[i]);
      rdc(csf_pkg::SYS_CTRL_OFS);
    end
    $display("sleep gating done");
    report_and_stop();
  end
endmodule : csf_clock_select_tb
